// ---- common/fault_regs.vh ----
/*
 * register offsets, field positions, reset values and fault codes of the
 * servo fault supervisor. assumes inclusion by bare name from design files.
 */
`ifndef FAULT_REGS_VH
`define FAULT_REGS_VH

// register word addresses (plain 8-bit address port)
`define ADDR_CTRL 8'h00
`define ADDR_OVERSPEED 8'h01
`define ADDR_ERR_LIMIT 8'h02
`define ADDR_FC_ERR_LIMIT 8'h03
`define ADDR_SOFT_LOW 8'h04
`define ADDR_SOFT_HIGH 8'h05
`define ADDR_FUNC_MAP_BASE 8'h08
`define ADDR_STATUS 8'h10
`define ADDR_MASK 8'h11
`define ADDR_CODE 8'h12
`define ADDR_RPDO_TIMEOUT 8'h13

// control register field positions
`define CTRL_SOFT_LIMIT_EN 0
`define CTRL_FIXED_LEN_USE 1
`define CTRL_FWD_STROKE_REQ 2
`define CTRL_REV_STROKE_REQ 3
`define CTRL_RPDO_WATCH_EN 4

// reset values
`define CTRL_RESET 32'h00000000
`define OVERSPEED_RESET 32'h00000078
`define ERR_LIMIT_RESET 32'h00000000
`define RPDO_TIMEOUT_RESET 32'h0001e848
`define SOFT_LOW_RESET 32'h80000000
`define SOFT_HIGH_RESET 32'h7fffffff

// input function numbers
`define FUNC_HOME_SWITCH 6'h22
`define FUNC_FIXED_LEN_TRIG 6'h28
`define FUNC_FWD_STROKE 6'h2b
`define FUNC_REV_STROKE 6'h2c

// status bit positions of each fault
`define BIT_HOME_UNMAPPED 0
`define BIT_DUP_ASSIGN 1
`define BIT_OVERSPEED 2
`define BIT_POS_ERROR 3
`define BIT_FIXED_LEN_UNMAPPED 4
`define BIT_NOT_HOMED 5
`define BIT_MOTOR_OVERLOAD 6
`define BIT_SOFT_LIMIT 7
`define BIT_FC_POS_ERROR 8
`define BIT_INDEX_UNSTABLE 9
`define BIT_RPDO_TIMEOUT 10
`define BIT_MOTOR_STALL 11
`define BIT_BRAKE_OVERLOAD 12
`define BIT_FWD_UNMAPPED 13
`define BIT_REV_UNMAPPED 14
`define NUM_FAULTS 15

// reported fault codes
`define CODE_NONE 9'h000
`define CODE_HOME_UNMAPPED 9'h0c8
`define CODE_DUP_ASSIGN 9'h0c9
`define CODE_OVERSPEED 9'h0ca
`define CODE_POS_ERROR 9'h0cb
`define CODE_FIXED_LEN_UNMAPPED 9'h0cc
`define CODE_NOT_HOMED 9'h0cd
`define CODE_MOTOR_OVERLOAD 9'h0ce
`define CODE_SOFT_LIMIT 9'h0cf
`define CODE_FC_POS_ERROR 9'h0d5
`define CODE_INDEX_UNSTABLE 9'h0d8
`define CODE_RPDO_TIMEOUT 9'h0d9
`define CODE_RESERVED 9'h0da
`define CODE_MOTOR_STALL 9'h0db
`define CODE_BRAKE_OVERLOAD 9'h0dc
`define CODE_FWD_UNMAPPED 9'h0dd
`define CODE_REV_UNMAPPED 9'h0de

`endif

// ---- design/func_map_check.v ----
/*
 * checks the input-function map of the digital input terminals: finds
 * functions mapped twice and tells which needed functions are mapped.
 * assumes the map is registered in the same clock domain.
 */
`include "fault_regs.vh"

module func_map_check #(
  parameter NUM_TERMINALS = 8
) (
  // function number of each terminal, 6 bits each, 0 means unused
  input wire [6*NUM_TERMINALS-1:0] func_map,
  // results
  output reg dup_found,
  output reg home_mapped,
  output reg fixed_len_mapped,
  output reg fwd_mapped,
  output reg rev_mapped
);

  integer i;
  integer j;

  // pairwise compare; small terminal count keeps this cheap
  always @* begin
    dup_found = 1'b0;
    home_mapped = 1'b0;
    fixed_len_mapped = 1'b0;
    fwd_mapped = 1'b0;
    rev_mapped = 1'b0;
    for (i = 0; i < NUM_TERMINALS; i = i + 1) begin
      if (func_map[6*i +: 6] == `FUNC_HOME_SWITCH)
        home_mapped = 1'b1;
      if (func_map[6*i +: 6] == `FUNC_FIXED_LEN_TRIG)
        fixed_len_mapped = 1'b1;
      if (func_map[6*i +: 6] == `FUNC_FWD_STROKE)
        fwd_mapped = 1'b1;
      if (func_map[6*i +: 6] == `FUNC_REV_STROKE)
        rev_mapped = 1'b1;
      for (j = i + 1; j < NUM_TERMINALS; j = j + 1) begin
        if (func_map[6*i +: 6] != 6'h00 &&
            func_map[6*i +: 6] == func_map[6*j +: 6])
          dup_found = 1'b1;
      end
    end
  end

endmodule // func_map_check

// ---- design/servo_fault_supervisor.v ----
/*
 * servo fault supervisor: compares speed, following error and encoder
 * position against limits, checks the input-function map, latches fault
 * bits and reports the lowest-numbered pending fault code.
 * assumes speed/position inputs come from logic on ref_clk; event pins
 * from outside are synchronised here. registers reached by a plain port.
 */
// The register addresses and the plain strobed port were left to the implementer.
`include "fault_regs.vh"

module servo_fault_supervisor #(
  parameter NUM_TERMINALS = 8,
  parameter [31:0] RPDO_TIMEOUT_CYCLES = `RPDO_TIMEOUT_RESET
) (
  // clock, reset, enable
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  // register port
  input wire [7:0] addr,
  input wire [31:0] wr_data,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rd_data,
  // measurements from the drive loop, same clock
  input wire [15:0] speed_percent,
  input wire [31:0] following_error_value,
  input wire [31:0] fc_error_value,
  input wire signed [31:0] encoder_position,
  // requests from the motion logic, same clock
  input wire home_request,
  input wire home_done,
  input wire ref_lost,
  input wire abs_move_request,
  output wire abs_move_accept,
  // event pins from outside, asynchronous
  input wire index_unstable_pin,
  input wire overload_pin,
  input wire stall_pin,
  input wire brake_overload_pin,
  input wire rpdo_arrived_pin,
  // fault report
  output reg [8:0] fault_code,
  output wire irq
);

  localparam NF = `NUM_FAULTS;
  // reset word of the threshold; only its low half is kept in a register
  localparam [31:0] OS_RESET_WORD = `OVERSPEED_RESET;

  // registers
  reg [31:0] ctrl_reg;
  reg [15:0] overspeed_percent_threshold;
  reg [31:0] following_error_limit;
  reg [31:0] fc_error_limit;
  reg signed [31:0] soft_low_reg;
  reg signed [31:0] soft_high_reg;
  reg [6*NUM_TERMINALS-1:0] func_map_reg;
  reg [NF-1:0] status_reg;
  reg [NF-1:0] mask_reg;
  reg [31:0] rpdo_timeout_reg;
  reg [31:0] rpdo_count_reg;
  reg homed_reg;
  reg [4:0] sync1_reg;
  reg [4:0] sync2_reg;
  reg [4:0] sync3_reg;

  wire dup_found;
  wire home_mapped;
  wire fixed_len_mapped;
  wire fwd_mapped;
  wire rev_mapped;
  wire soft_limit_enable;
  wire [4:0] pin_rise;
  wire rpdo_seen;
  reg [NF-1:0] event_now;
  reg [8:0] code_next;
  integer k;
  // one loop index per process, so no index is shared between processes
  // and the combinational scan is never woken by a clocked loop
  integer wk;
  integer rk;

  assign soft_limit_enable = ctrl_reg[`CTRL_SOFT_LIMIT_EN];

  func_map_check #(
    .NUM_TERMINALS(NUM_TERMINALS)
  ) map_check (
    .func_map(func_map_reg),
    .dup_found(dup_found),
    .home_mapped(home_mapped),
    .fixed_len_mapped(fixed_len_mapped),
    .fwd_mapped(fwd_mapped),
    .rev_mapped(rev_mapped)
  );

  // returns the reported code of a status bit
  function [8:0] code_of;
    input integer b;
    begin
      case (b)
        `BIT_HOME_UNMAPPED: code_of = `CODE_HOME_UNMAPPED;
        `BIT_DUP_ASSIGN: code_of = `CODE_DUP_ASSIGN;
        `BIT_OVERSPEED: code_of = `CODE_OVERSPEED;
        `BIT_POS_ERROR: code_of = `CODE_POS_ERROR;
        `BIT_FIXED_LEN_UNMAPPED: code_of = `CODE_FIXED_LEN_UNMAPPED;
        `BIT_NOT_HOMED: code_of = `CODE_NOT_HOMED;
        `BIT_MOTOR_OVERLOAD: code_of = `CODE_MOTOR_OVERLOAD;
        `BIT_SOFT_LIMIT: code_of = `CODE_SOFT_LIMIT;
        `BIT_FC_POS_ERROR: code_of = `CODE_FC_POS_ERROR;
        `BIT_INDEX_UNSTABLE: code_of = `CODE_INDEX_UNSTABLE;
        `BIT_RPDO_TIMEOUT: code_of = `CODE_RPDO_TIMEOUT;
        `BIT_MOTOR_STALL: code_of = `CODE_MOTOR_STALL;
        `BIT_BRAKE_OVERLOAD: code_of = `CODE_BRAKE_OVERLOAD;
        `BIT_FWD_UNMAPPED: code_of = `CODE_FWD_UNMAPPED;
        `BIT_REV_UNMAPPED: code_of = `CODE_REV_UNMAPPED;
        default: code_of = `CODE_NONE; // reserved code has no bit
      endcase
    end
  endfunction

  // two-flop synchronisers, third stage only for edge detection
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      sync3_reg <= 5'h00;
    end else if (clk_en) begin
      sync1_reg <= {rpdo_arrived_pin, brake_overload_pin, stall_pin,
                    overload_pin, index_unstable_pin};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign pin_rise = sync2_reg & ~sync3_reg;
  assign rpdo_seen = pin_rise[4];

  // absolute moves only pass once homing holds a position reference
  assign abs_move_accept = abs_move_request & homed_reg;

  // fault conditions in this cycle
  always @* begin
    event_now = {NF{1'b0}};
    event_now[`BIT_HOME_UNMAPPED] = home_request & ~home_mapped;
    event_now[`BIT_DUP_ASSIGN] = dup_found;
    event_now[`BIT_OVERSPEED] =
      speed_percent > overspeed_percent_threshold;
    event_now[`BIT_POS_ERROR] = (following_error_limit != 32'h00000000) &&
      (following_error_value > following_error_limit);
    event_now[`BIT_FIXED_LEN_UNMAPPED] =
      ctrl_reg[`CTRL_FIXED_LEN_USE] & ~fixed_len_mapped;
    event_now[`BIT_NOT_HOMED] = abs_move_request & ~homed_reg;
    event_now[`BIT_MOTOR_OVERLOAD] = pin_rise[1];
    event_now[`BIT_SOFT_LIMIT] = soft_limit_enable &&
      ((encoder_position < soft_low_reg) ||
       (encoder_position > soft_high_reg));
    event_now[`BIT_FC_POS_ERROR] = (fc_error_limit != 32'h00000000) &&
      (fc_error_value > fc_error_limit);
    event_now[`BIT_INDEX_UNSTABLE] = pin_rise[0];
    event_now[`BIT_RPDO_TIMEOUT] = ctrl_reg[`CTRL_RPDO_WATCH_EN] &&
      ~rpdo_seen && (rpdo_count_reg >= rpdo_timeout_reg);
    event_now[`BIT_MOTOR_STALL] = pin_rise[2];
    event_now[`BIT_BRAKE_OVERLOAD] = pin_rise[3];
    event_now[`BIT_FWD_UNMAPPED] =
      ctrl_reg[`CTRL_FWD_STROKE_REQ] & ~fwd_mapped;
    event_now[`BIT_REV_UNMAPPED] =
      ctrl_reg[`CTRL_REV_STROKE_REQ] & ~rev_mapped;
  end

  // lowest pending bit gives the displayed code; scan from the top down
  always @* begin
    code_next = `CODE_NONE;
    for (k = NF - 1; k >= 0; k = k - 1) begin
      if (status_reg[k])
        code_next = code_of(k);
    end
  end

  // homing state: lost on reference loss, regained by completed homing
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      homed_reg <= 1'b0;
    end else if (clk_en) begin
      if (ref_lost)
        homed_reg <= 1'b0;
      else if (home_done)
        homed_reg <= 1'b1;
    end
  end

  // receive watchdog; restarts on each arrival, saturates at timeout
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rpdo_count_reg <= 32'h00000000;
    end else if (clk_en) begin
      if (rpdo_seen || !ctrl_reg[`CTRL_RPDO_WATCH_EN])
        rpdo_count_reg <= 32'h00000000;
      else if (rpdo_count_reg < rpdo_timeout_reg)
        rpdo_count_reg <= rpdo_count_reg + 32'h00000001;
    end
  end

  // configuration registers
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `CTRL_RESET;
      overspeed_percent_threshold <= OS_RESET_WORD[15:0];
      following_error_limit <= `ERR_LIMIT_RESET;
      fc_error_limit <= `ERR_LIMIT_RESET;
      soft_low_reg <= `SOFT_LOW_RESET;
      soft_high_reg <= `SOFT_HIGH_RESET;
      func_map_reg <= {6*NUM_TERMINALS{1'b0}};
      mask_reg <= {NF{1'b0}};
      rpdo_timeout_reg <= RPDO_TIMEOUT_CYCLES;
    end else if (clk_en && wr_stb) begin
      case (addr)
        `ADDR_CTRL: ctrl_reg <= wr_data;
        `ADDR_OVERSPEED: overspeed_percent_threshold <= wr_data[15:0];
        `ADDR_ERR_LIMIT: following_error_limit <= wr_data;
        `ADDR_FC_ERR_LIMIT: fc_error_limit <= wr_data;
        `ADDR_SOFT_LOW: soft_low_reg <= wr_data;
        `ADDR_SOFT_HIGH: soft_high_reg <= wr_data;
        `ADDR_MASK: mask_reg <= wr_data[NF-1:0];
        `ADDR_RPDO_TIMEOUT: rpdo_timeout_reg <= wr_data;
        default: begin
          for (wk = 0; wk < NUM_TERMINALS; wk = wk + 1) begin
            if (addr == `ADDR_FUNC_MAP_BASE + wk[7:0])
              func_map_reg[6*wk +: 6] <= wr_data[5:0];
          end
        end
      endcase
    end
  end

  // sticky fault bits: write one to clear, a new event wins the clear
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_reg <= {NF{1'b0}};
      fault_code <= `CODE_NONE;
    end else if (clk_en) begin
      if (wr_stb && addr == `ADDR_STATUS)
        status_reg <= (status_reg & ~wr_data[NF-1:0]) | event_now;
      else
        status_reg <= status_reg | event_now;
      fault_code <= code_next;
    end
  end

  // level interrupt while an unmasked fault is pending
  assign irq = |(status_reg & mask_reg);

  // read port, data one cycle after the strobe; unmapped reads as zero
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 32'h00000000;
    end else if (clk_en) begin
      rd_data <= 32'h00000000;
      if (rd_stb) begin
        case (addr)
          `ADDR_CTRL: rd_data <= ctrl_reg;
          `ADDR_OVERSPEED: rd_data <= {16'h0000, overspeed_percent_threshold};
          `ADDR_ERR_LIMIT: rd_data <= following_error_limit;
          `ADDR_FC_ERR_LIMIT: rd_data <= fc_error_limit;
          `ADDR_SOFT_LOW: rd_data <= soft_low_reg;
          `ADDR_SOFT_HIGH: rd_data <= soft_high_reg;
          `ADDR_STATUS: rd_data <= {{32-NF{1'b0}}, status_reg};
          `ADDR_MASK: rd_data <= {{32-NF{1'b0}}, mask_reg};
          `ADDR_CODE: rd_data <= {23'h000000, fault_code};
          `ADDR_RPDO_TIMEOUT: rd_data <= rpdo_timeout_reg;
          default: begin
            for (rk = 0; rk < NUM_TERMINALS; rk = rk + 1) begin
              if (addr == `ADDR_FUNC_MAP_BASE + rk[7:0])
                rd_data <= {26'h0000000, func_map_reg[6*rk +: 6]};
            end
          end
        endcase
      end
    end
  end

endmodule // servo_fault_supervisor

// ---- tb/fault_sva.sv ----
/*
 checker for the servo fault supervisor, watching its ports only.
 assumes one clock domain and that limits are learnt by snooping writes.
*/
`include "fault_regs.vh"

module fault_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rd_data,
  // measurements and motion
  input wire logic [15:0] speed_percent,
  input wire logic [31:0] following_error_value,
  input wire logic home_done,
  input wire logic ref_lost,
  input wire logic abs_move_request,
  input wire logic abs_move_accept,
  // report
  input wire logic [8:0] fault_code,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] os_thr;
  logic [31:0] err_lim;
  logic [31:0] mask_q;
  logic seen_home;
  logic st_wr;

  // shadow copies of the limits, so no peeking inside is needed
  assign st_wr = wr_stb && addr == `ADDR_STATUS;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      os_thr <= `OVERSPEED_RESET;
      err_lim <= `ERR_LIMIT_RESET;
      mask_q <= 32'h0;
      seen_home <= 1'b0;
    end else if (clk_en) begin
      if (wr_stb && addr == `ADDR_OVERSPEED)
        os_thr <= wr_data;
      if (wr_stb && addr == `ADDR_ERR_LIMIT)
        err_lim <= wr_data;
      if (wr_stb && addr == `ADDR_MASK)
        mask_q <= wr_data;
      if (home_done)
        seen_home <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_no_reserved: assert property (fault_code != `CODE_RESERVED)
    else $error("reserved fault code reported");
  a_os_raise: assert property (clk_en && speed_percent > os_thr[15:0]
    |-> ##[1:3] fault_code != `CODE_NONE)
    else $error("overspeed not reported");
  a_err_raise: assert property (clk_en && err_lim != 32'h0
    && following_error_value > err_lim |-> ##[1:3] fault_code != 9'h000)
    else $error("following error not reported");
  a_abs_refuse: assert property (abs_move_accept
    |-> abs_move_request && seen_home)
    else $error("absolute move accepted before homing");
  a_abs_grant: assert property (abs_move_request && $past(home_done)
    && !$past(ref_lost) && $past(clk_en) |-> abs_move_accept)
    else $error("absolute move refused after homing");
  a_code_known: assert property (fault_code inside {`CODE_NONE,
    `CODE_HOME_UNMAPPED, `CODE_DUP_ASSIGN, `CODE_OVERSPEED,
    `CODE_POS_ERROR, `CODE_FIXED_LEN_UNMAPPED, `CODE_NOT_HOMED,
    `CODE_MOTOR_OVERLOAD, `CODE_SOFT_LIMIT, `CODE_FC_POS_ERROR,
    `CODE_INDEX_UNSTABLE, `CODE_RPDO_TIMEOUT, `CODE_MOTOR_STALL,
    `CODE_BRAKE_OVERLOAD, `CODE_FWD_UNMAPPED, `CODE_REV_UNMAPPED})
    else $error("unknown fault code reported");
  // a pending code may only go away within two edges after a status write
  a_fault_held: assert property (fault_code != 9'h000 && clk_en
    && !st_wr && !$past(st_wr) |=> fault_code != 9'h000)
    else $error("fault code dropped without a clear");
  a_rd_quiet: assert property ($past(clk_en) && !$past(rd_stb)
    |-> rd_data == 32'h0)
    else $error("read data outside the read answer cycle");
  a_irq_masked: assert property (mask_q == 32'h0 |-> !irq)
    else $error("interrupt raised with all sources masked");
endmodule // fault_sva

// ---- tb/motor_side.sv ----
/*
 model of the motor, encoder and terminal side of the supervisor.
 assumes the bench calls its tasks just after a rising ref_clk edge.
*/
module motor_side (
  // clock
  input wire logic ref_clk,
  // measurements
  output logic [15:0] speed_percent,
  output logic [31:0] fe_value,
  output logic [31:0] fc_value,
  output logic signed [31:0] position,
  // event pins: index, overload, stall, brake, rpdo arrival
  output logic [4:0] ev
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet motor at time zero
  initial begin
    speed_percent = 16'h0;
    fe_value = 32'h0;
    fc_value = 32'h0;
    position = 32'sh0;
    ev = 5'h0;
  end

  // new loop readings land together on one edge
  task automatic set(input logic [15:0] s, input logic [31:0] fe,
    input logic [31:0] fc, input logic signed [31:0] p);
    @(posedge ref_clk);
    speed_percent <= s;
    fe_value <= fe;
    fc_value <= fc;
    position <= p;
  endtask

  // pulse wide enough to survive the two-flop sync
  task automatic pulse(input int i);
    @(posedge ref_clk);
    ev[i] <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ev[i] <= 1'b0;
  endtask
endmodule // motor_side

// ---- tb/tb.sv ----
/*
 self-checking bench for the servo fault supervisor.
 assumes the register map and codes of fault_regs.vh, timeout set to 20.
*/
`include "fault_regs.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst = 1, clk_en = 1, wr_stb = 0, rd_stb = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic home_request = 0, home_done = 0, ref_lost = 0, abs_req = 0;
  wire [31:0] rd_data, fe, fc;
  wire signed [31:0] pos;
  wire [15:0] spd;
  wire [8:0] fault_code;
  wire [4:0] ev;
  wire irq, abs_ok;
  int err_count = 0, checked = 0;
  int pin_bit [4] = '{9, 6, 11, 12};
  logic [8:0] pin_code [4] = '{`CODE_INDEX_UNSTABLE, `CODE_MOTOR_OVERLOAD,
    `CODE_MOTOR_STALL, `CODE_BRAKE_OVERLOAD};
  int req_bit [3] = '{4, 13, 14};
  logic [8:0] req_code [3] = '{`CODE_FIXED_LEN_UNMAPPED,
    `CODE_FWD_UNMAPPED, `CODE_REV_UNMAPPED};
  logic [31:0] lim [2] = '{32'd101, -32'sd101};
  logic [5:0] fmap [4] = '{`FUNC_HOME_SWITCH, `FUNC_FIXED_LEN_TRIG,
    `FUNC_FWD_STROKE, `FUNC_REV_STROKE};

  always #4 ref_clk = ~ref_clk;

  servo_fault_supervisor #(.RPDO_TIMEOUT_CYCLES(32'd20)) uut (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .speed_percent(spd), .following_error_value(fe), .fc_error_value(fc),
    .encoder_position(pos), .home_request(home_request),
    .home_done(home_done), .ref_lost(ref_lost), .abs_move_request(abs_req),
    .abs_move_accept(abs_ok), .index_unstable_pin(ev[0]),
    .overload_pin(ev[1]), .stall_pin(ev[2]), .brake_overload_pin(ev[3]),
    .rpdo_arrived_pin(ev[4]), .fault_code(fault_code), .irq(irq));

  motor_side u_m (.ref_clk(ref_clk), .speed_percent(spd), .fe_value(fe),
    .fc_value(fc), .position(pos), .ev(ev));

  task automatic cmp(input string n, input logic [31:0] e,
    input logic [31:0] s);
    checked++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr_stb <= 1;
    addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_stb <= 0;
  endtask

  // answer stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input string n);
    @(posedge ref_clk);
    rd_stb <= 1;
    addr <= a;
    @(posedge ref_clk);
    rd_stb <= 0;
    #1 cmp(n, e, rd_data);
  endtask

  // one fault pending: its code, its status bit and the interrupt
  task automatic hit(input int b, input logic [8:0] c);
    repeat (6) @(posedge ref_clk);
    #1 cmp("fault_code", {23'h0, c}, {23'h0, fault_code});
    cmp("irq", 32'h1, {31'h0, irq});
    rd(`ADDR_STATUS, 32'h1 << b, "status");
  endtask

  // cause already gone: bit must stay until written with a one
  task automatic clr(input int b);
    repeat (4) @(posedge ref_clk);
    rd(`ADDR_STATUS, 32'h1 << b, "latched");
    wr(`ADDR_STATUS, 32'h1 << b);
    rd(`ADDR_STATUS, 32'h0, "cleared");
    #1 cmp("irq_low", 32'h0, {31'h0, irq});
  endtask

  task automatic quiet(input string n);
    repeat (6) @(posedge ref_clk);
    rd(`ADDR_STATUS, 32'h0, n);
  endtask

  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    rd(`ADDR_OVERSPEED, `OVERSPEED_RESET, "os_reset");
    rd(`ADDR_RPDO_TIMEOUT, 32'd20, "rpdo_reset");
    rd(`ADDR_ERR_LIMIT, `ERR_LIMIT_RESET, "lim_reset");
    rd(`ADDR_CTRL, `CTRL_RESET, "ctrl_reset");
    rd(8'h20, 32'h0, "unmapped");
    wr(`ADDR_CODE, 32'h1ff);
    rd(`ADDR_CODE, 32'h0, "code_ro");
    wr(`ADDR_MASK, 32'h7fff);
    clk_en <= 0;
    u_m.set(16'd121, 0, 0, 0);
    repeat (4) @(posedge ref_clk);
    u_m.set(16'd0, 0, 0, 0);
    clk_en <= 1;
    quiet("frozen");
    u_m.set(16'd120, 0, 0, 0);
    quiet("os_equal");
    u_m.set(16'd121, 0, 0, 0);
    hit(2, `CODE_OVERSPEED);
    wr(`ADDR_MASK, 32'h0);
    #1 cmp("irq_masked", 32'h0, {31'h0, irq});
    wr(`ADDR_MASK, 32'h7fff);
    u_m.set(0, 32'd1000, 0, 0);
    clr(2);
    quiet("err_off");
    wr(`ADDR_ERR_LIMIT, 32'd1000);
    quiet("err_equal");
    u_m.set(0, 32'd1001, 0, 0);
    hit(3, `CODE_POS_ERROR);
    u_m.set(0, 0, 32'd51, 0);
    clr(3);
    wr(`ADDR_FC_ERR_LIMIT, 32'd50);
    hit(8, `CODE_FC_POS_ERROR);
    u_m.set(0, 0, 0, 32'sd101);
    clr(8);
    wr(`ADDR_SOFT_LOW, -32'sd100);
    wr(`ADDR_SOFT_HIGH, 32'd100);
    quiet("soft_off");
    wr(`ADDR_CTRL, 32'h1);
    for (int i = 0; i < 2; i++) begin
      u_m.set(0, 0, 0, lim[i]);
      hit(7, `CODE_SOFT_LIMIT);
      u_m.set(0, 0, 0, 0);
      clr(7);
    end
    wr(`ADDR_CTRL, 32'h0);
    home_request <= 1;
    hit(0, `CODE_HOME_UNMAPPED);
    home_request <= 0;
    clr(0);
    for (int i = 0; i < 3; i++) begin
      wr(`ADDR_CTRL, 32'h2 << i);
      hit(req_bit[i], req_code[i]);
      wr(`ADDR_CTRL, 32'h0);
      clr(req_bit[i]);
    end
    wr(`ADDR_FUNC_MAP_BASE, 32'h5);
    wr(`ADDR_FUNC_MAP_BASE + 8'h1, 32'h5);
    hit(1, `CODE_DUP_ASSIGN);
    for (int i = 0; i < 4; i++)
      wr(`ADDR_FUNC_MAP_BASE + 8'(i), {26'h0, fmap[i]});
    clr(1);
    home_request <= 1;
    wr(`ADDR_CTRL, 32'he);
    quiet("all_mapped");
    home_request <= 0;
    wr(`ADDR_CTRL, 32'h0);
    abs_req <= 1;
    #1 cmp("abs_refused", 32'h0, {31'h0, abs_ok});
    hit(5, `CODE_NOT_HOMED);
    home_done <= 1;
    @(posedge ref_clk);
    home_done <= 0;
    #1 cmp("abs_accept", 32'h1, {31'h0, abs_ok});
    ref_lost <= 1;
    @(posedge ref_clk);
    ref_lost <= 0;
    #1 cmp("abs_lost", 32'h0, {31'h0, abs_ok});
    abs_req <= 0;
    clr(5);
    for (int i = 0; i < 4; i++) begin
      u_m.pulse(i);
      hit(pin_bit[i], pin_code[i]);
      clr(pin_bit[i]);
    end
    wr(`ADDR_CTRL, 32'h10);
    for (int i = 0; i < 4; i++) begin
      repeat (12) @(posedge ref_clk);
      u_m.pulse(4);
    end
    quiet("rpdo_fed");
    repeat (24) @(posedge ref_clk);
    hit(10, `CODE_RPDO_TIMEOUT);
    wr(`ADDR_CTRL, 32'h0);
    clr(10);
    #1 cmp("code_idle", 32'h0, {23'h0, fault_code});
    summarize();
  end
endmodule // tb

bind servo_fault_supervisor fault_sva u_sva (.ref_clk(ref_clk), .rst(rst),
  .clk_en(clk_en), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rd_data(rd_data), .speed_percent(speed_percent),
  .following_error_value(following_error_value), .home_done(home_done),
  .ref_lost(ref_lost), .abs_move_request(abs_move_request),
  .abs_move_accept(abs_move_accept), .fault_code(fault_code), .irq(irq));
